// ### logic/cpa_bank.sv
// Private configuration registers of the logical devices, 30h..FFh,
// with the relocatable I/O base held apart at 60h/61h.
// Assumes priv_wr pulses only for accepted data-port writes.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
module cpa_bank (
  // Clock and reset
  input  wire logic   clk_sys_in,
  input  wire logic   rst_in,
  input  wire logic   ce_in,
  // Core side
  cpa_core_if.bank    ifc
);
  import cpa_pkg::*;

  localparam logic [`CPA_NUM_DEV-1:0] BASE_PROG = `CPA_BASE_PROG;
  localparam cpa_base_t [`CPA_NUM_DEV-1:0] BASE_RST = {
    `CPA_BASE_F, `CPA_BASE_E, `CPA_BASE_D, `CPA_BASE_NONE,
    `CPA_BASE_NONE, `CPA_BASE_NONE, `CPA_BASE_NONE, `CPA_BASE_NONE,
    `CPA_BASE_NONE, `CPA_BASE_6, `CPA_BASE_5, `CPA_BASE_NONE,
    `CPA_BASE_3, `CPA_BASE_2, `CPA_BASE_1, `CPA_BASE_0};

  cpa_byte_t priv_mem [`CPA_NUM_DEV][`CPA_NUM_PRIV];
  cpa_byte_t offset;
  logic      dev_ok;
  logic      is_base;

  assign offset  = 8'(ifc.index - `CPA_IDX_PRIV);
  assign dev_ok  = (ifc.device != `CPA_DEV_RSVD);
  assign is_base = (ifc.index == `CPA_IDX_BASE_HI) ||
                   (ifc.index == `CPA_IDX_BASE_LO);

  // Set chosen by the latched device number
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int d = 0; d < `CPA_NUM_DEV; d++) begin
        for (int r = 0; r < `CPA_NUM_PRIV; r++) begin
          priv_mem[d][r] <= 8'h00;
        end
      end
    end else if (ce_in && ifc.priv_wr && dev_ok && !is_base) begin
      priv_mem[ifc.device][offset] <= ifc.wdata;
    end
  end

  for (genvar d = 0; d < `CPA_NUM_DEV; d++) begin : g_dev
    cpa_base_t base_q;
    cpa_base_t next_base;
    always_comb begin
      next_base = base_q;
      if (ifc.priv_wr && ifc.device == 4'(d) && BASE_PROG[d]) begin
        if (ifc.index == `CPA_IDX_BASE_HI) begin
          next_base[11:8] = ifc.wdata[3:0];
        end else if (ifc.index == `CPA_IDX_BASE_LO) begin
          next_base[7:0] = ifc.wdata;
        end
      end
    end
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        base_q <= BASE_RST[d];
      end else if (ce_in) begin
        base_q <= next_base;
      end
    end
    assign ifc.base[d]   = base_q;
    assign ifc.active[d] = priv_mem[d][0][`CPA_ACT_BIT];
  end

  always_comb begin
    ifc.priv_rdata = 8'h00;
    if (!dev_ok) begin
      ifc.priv_rdata = 8'h00;
    end else if (ifc.index == `CPA_IDX_BASE_HI) begin
      ifc.priv_rdata = {4'h0, ifc.base[ifc.device][11:8]};
    end else if (ifc.index == `CPA_IDX_BASE_LO) begin
      ifc.priv_rdata = ifc.base[ifc.device][7:0];
    end else begin
      ifc.priv_rdata = priv_mem[ifc.device][offset];
    end
  end
endmodule // cpa_bank

// ### logic/cpa_cfg.svh
// Constants of the configuration access port: ports, keys, indices,
// reset values. Included by the block's modules and interface; no logic here.
`ifndef CPA_CFG_SVH
`define CPA_CFG_SVH

// Enable/index port pair and key values
`define CPA_PORT_PRI     16'h002e
`define CPA_PORT_ALT     16'h004e
`define CPA_PORT_STEP    16'h0001
`define CPA_KEY_ENTER    8'h87
`define CPA_KEY_EXIT     8'haa

// Global register indices
`define CPA_IDX_SWRST    8'h02
`define CPA_IDX_DEVSEL   8'h07
`define CPA_IDX_ID_HI    8'h20
`define CPA_IDX_ID_LO    8'h21
`define CPA_IDX_ALTOPT   8'h26
`define CPA_GLOB_PAGE    4'h2
`define CPA_ALT_BIT      6
`define CPA_SWRST_BIT    0

// Private register indices
`define CPA_IDX_PRIV     8'h30
`define CPA_IDX_BASE_HI  8'h60
`define CPA_IDX_BASE_LO  8'h61
`define CPA_ACT_BIT      0

// Global register page 20h..2Fh: writable entries and reset values
`define CPA_GLOB_WMASK   16'hf77c
`define CPA_RST_22       8'hff
`define CPA_RST_23       8'hf0
`define CPA_RST_24       8'h40
`define CPA_RST_2C       8'h02

// Logical devices
`define CPA_NUM_DEV      16
`define CPA_NUM_PRIV     208
`define CPA_DEV_RSVD     4'h4
`define CPA_BASE_PROG    16'he8ef
`define CPA_BASE_0       12'h3f0
`define CPA_BASE_1       12'h378
`define CPA_BASE_2       12'h3f8
`define CPA_BASE_3       12'h2f8
`define CPA_BASE_5       12'h060
`define CPA_BASE_6       12'h3e0
`define CPA_BASE_D       12'h2e0
`define CPA_BASE_E       12'h3e8
`define CPA_BASE_F       12'h2e8
`define CPA_BASE_NONE    12'h000

`endif

// ### logic/cpa_config_port.sv
// Configuration access port: decodes host I/O cycles at the enable,
// index and data ports, holds the global registers 07h and 20h..2Fh,
// and routes data-port cycles to the private register bank.
// Assumes one I/O cycle strobe per access, synchronous to clk_sys_in.
//
// Function
// - Two successive 0x87 writes to the enable port open configuration.
// - Index port shares the enable address; data port sits one above.
// - Index 07h then a data write latches the current logical device.
// - Global registers below 30h are reachable without device selection.
// - Data port reads or writes the register named by the index port.
// - Indices 30h and up reach the selected device's private set.
// - Writing 0xAA to the enable port leaves configuration mode.
// - Devices 0 to F exist; number 4 is reserved and inert.
// - Device numbers map to the fixed set of functions.
// - Relocatable devices hold a programmable base with given defaults.
// - Bit 6 of global register 26h moves the ports to 4Eh/4Fh.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
module cpa_config_port #(
  // Identity values are arbitrary
  parameter logic [7:0] CHIP_ID_HI = 8'h5a,
  parameter logic [7:0] CHIP_ID_LO = 8'h11
) (
  // Clock, reset, enable
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        ce_in,
  // Host I/O cycles
  input  wire logic [15:0]                 io_addr_in,
  input  wire cpa_pkg::cpa_byte_t          io_wdata_in,
  input  wire logic                        io_wr_in,
  input  wire logic                        io_rd_in,
  output cpa_pkg::cpa_byte_t               io_rdata_out,
  output logic                             io_rvalid_out,
  // Strap for the alternate port pair
  input  wire logic                        alt_strap_in,
  // Configuration state
  output logic                             cfg_mode_out,
  output cpa_pkg::cpa_dev_t                cur_device_out,
  output logic                             alt_port_out,
  output logic [`CPA_NUM_DEV-1:0]          dev_active_out,
  output logic [`CPA_NUM_DEV*12-1:0]       dev_base_out
);
  import cpa_pkg::*;

  // Device functions by number
  localparam cpa_dev_t DEV_FLOPPY  = 4'h0;
  localparam cpa_dev_t DEV_PARPORT = 4'h1;
  localparam cpa_dev_t DEV_SER_A   = 4'h2;
  localparam cpa_dev_t DEV_SER_B   = 4'h3;
  localparam cpa_dev_t DEV_KBC     = 4'h5;
  localparam cpa_dev_t DEV_SER_C   = 4'h6;
  localparam cpa_dev_t DEV_GPIO34  = 4'h7;
  localparam cpa_dev_t DEV_GPIO56  = 4'h8;
  localparam cpa_dev_t DEV_GPIO12  = 4'h9;
  localparam cpa_dev_t DEV_PWRMGT  = 4'ha;
  localparam cpa_dev_t DEV_HWMON   = 4'hb;
  localparam cpa_dev_t DEV_CPULINK = 4'hc;
  localparam cpa_dev_t DEV_SER_D   = 4'hd;
  localparam cpa_dev_t DEV_SER_E   = 4'he;
  localparam cpa_dev_t DEV_SER_F   = 4'hf;

  localparam logic [15:0] GLOB_WMASK = `CPA_GLOB_WMASK;

  cpa_core_if ifc ();

  // Port decode
  logic [15:0] port_base;
  logic        hit_index;
  logic        hit_data;
  logic        wr_index;
  logic        wr_data;
  logic        rd_index;
  logic        rd_data;
  logic        cfg_mode;
  logic        exit_wr;
  logic        in_glob;
  logic        glob_wr;
  logic        swrst;

  // Registered state
  cpa_byte_t   index_q;
  cpa_byte_t   next_index;
  cpa_dev_t    device_q;
  cpa_dev_t    next_device;
  logic        strap_q;
  logic        next_strap;
  logic        rst_seen_q;
  logic        strap_load;
  cpa_byte_t   rdata_q;
  cpa_byte_t   next_rdata;
  logic        rvalid_q;
  logic        next_rvalid;
  cpa_byte_t   glob_q [16];
  cpa_byte_t   rd_mux;

  assign cfg_mode  = ifc.cfg_mode;
  assign port_base = glob_q[6][`CPA_ALT_BIT] ?
                     `CPA_PORT_ALT : `CPA_PORT_PRI;
  assign hit_index = (io_addr_in == port_base);
  assign hit_data  = (io_addr_in == 16'(port_base + `CPA_PORT_STEP));

  assign wr_index  = io_wr_in && hit_index;
  assign rd_index  = io_rd_in && hit_index && cfg_mode;
  // Data port is dead while locked
  assign wr_data   = io_wr_in && hit_data && cfg_mode;
  assign rd_data   = io_rd_in && hit_data && cfg_mode;
  assign exit_wr   = wr_index && io_wdata_in == `CPA_KEY_EXIT;

  assign in_glob   = (index_q < `CPA_IDX_PRIV);
  assign glob_wr   = wr_data && in_glob &&
                     index_q[7:4] == `CPA_GLOB_PAGE &&
                     GLOB_WMASK[index_q[3:0]];
  assign swrst     = wr_data && index_q == `CPA_IDX_SWRST &&
                     io_wdata_in[`CPA_SWRST_BIT];

  // Enable-port writes reach the key sequencer in any mode while ce_in is high
  assign ifc.key_wr   = ce_in && wr_index;
  assign ifc.key_data = io_wdata_in;
  assign ifc.priv_wr  = wr_data && !in_glob;
  assign ifc.device   = device_q;
  assign ifc.index    = index_q;
  assign ifc.wdata    = io_wdata_in;

  cpa_unlock u_unlock (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .ifc        (ifc)
  );

  cpa_bank u_bank (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .ifc        (ifc)
  );

  // Strap sampled on the first enabled edge after reset release
  assign strap_load = rst_seen_q && !rst_in;

  function automatic cpa_byte_t glob_rst(input int idx);
    case (idx)
      2:       glob_rst = `CPA_RST_22;
      3:       glob_rst = `CPA_RST_23;
      4:       glob_rst = `CPA_RST_24;
      12:      glob_rst = `CPA_RST_2C;
      default: glob_rst = 8'h00;
    endcase
  endfunction

  for (genvar g = 0; g < 16; g++) begin : g_glob
    cpa_byte_t next_glob;
    always_comb begin
      next_glob = glob_q[g];
      if (swrst) begin
        next_glob = glob_rst(g);
        if (g == 6) begin
          next_glob[`CPA_ALT_BIT] = strap_q;
        end
      end else if (glob_wr && index_q[3:0] == 4'(g)) begin
        next_glob = io_wdata_in;
      end
      if (g == 6 && strap_load) begin
        next_glob[`CPA_ALT_BIT] = alt_strap_in;
      end
    end
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        glob_q[g] <= glob_rst(g);
      end else if (ce_in) begin
        glob_q[g] <= next_glob;
      end
    end
  end

  // Index, device select, strap copy
  always_comb begin
    next_index  = index_q;
    next_device = device_q;
    next_strap  = strap_q;
    if (wr_index && cfg_mode && !exit_wr) begin
      next_index = io_wdata_in;
    end
    if (wr_data && index_q == `CPA_IDX_DEVSEL) begin
      next_device = io_wdata_in[3:0];
    end else if (swrst) begin
      next_device = DEV_FLOPPY;
    end
    if (strap_load) begin
      next_strap = alt_strap_in;
    end
  end

  // Read path
  always_comb begin
    rd_mux = 8'h00;
    if (rd_index) begin
      rd_mux = index_q;
    end else if (!in_glob) begin
      rd_mux = ifc.priv_rdata;
    end else if (index_q == `CPA_IDX_DEVSEL) begin
      rd_mux = {4'h0, device_q};
    end else if (index_q == `CPA_IDX_ID_HI) begin
      rd_mux = CHIP_ID_HI;
    end else if (index_q == `CPA_IDX_ID_LO) begin
      rd_mux = CHIP_ID_LO;
    end else if (index_q[7:4] == `CPA_GLOB_PAGE) begin
      rd_mux = glob_q[index_q[3:0]];
    end
  end

  always_comb begin
    next_rdata  = rdata_q;
    next_rvalid = 1'b0;
    if (rd_index || rd_data) begin
      next_rdata  = rd_mux;
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      index_q    <= 8'h00;
      device_q   <= DEV_FLOPPY;
      strap_q    <= 1'b0;
      rst_seen_q <= 1'b1;
      rdata_q    <= 8'h00;
      rvalid_q   <= 1'b0;
    end else if (ce_in) begin
      index_q    <= next_index;
      device_q   <= next_device;
      strap_q    <= next_strap;
      rst_seen_q <= 1'b0;
      rdata_q    <= next_rdata;
      rvalid_q   <= next_rvalid;
    end
  end

  assign io_rdata_out   = rdata_q;
  assign io_rvalid_out  = rvalid_q;
  assign cfg_mode_out   = cfg_mode;
  assign cur_device_out = device_q;
  assign alt_port_out   = glob_q[6][`CPA_ALT_BIT];
  assign dev_active_out = ifc.active;
  assign dev_base_out   = ifc.base;
endmodule // cpa_config_port

// ### logic/cpa_core_if.sv
// Internal carrier between the port core, the key sequencer and the
// private register bank. Assumes one clock domain.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
interface cpa_core_if;
  import cpa_pkg::*;
  logic                               key_wr;
  cpa_byte_t                          key_data;
  logic                               cfg_mode;
  logic                               priv_wr;
  cpa_dev_t                           device;
  cpa_byte_t                          index;
  cpa_byte_t                          wdata;
  cpa_byte_t                          priv_rdata;
  logic [`CPA_NUM_DEV-1:0]            active;
  cpa_base_t [`CPA_NUM_DEV-1:0]       base;

  modport unlock (
    input  key_wr,
    input  key_data,
    output cfg_mode
  );
  modport bank (
    input  priv_wr,
    input  device,
    input  index,
    input  wdata,
    output priv_rdata,
    output active,
    output base
  );
  modport core (
    output key_wr,
    output key_data,
    input  cfg_mode,
    output priv_wr,
    output device,
    output index,
    output wdata,
    input  priv_rdata,
    input  active,
    input  base
  );
endinterface

// ### logic/cpa_pkg.sv
// Types shared by the configuration access port modules.
// Constants live in cpa_cfg.svh.
package cpa_pkg;
  typedef logic [7:0]  cpa_byte_t;
  typedef logic [3:0]  cpa_dev_t;
  typedef logic [11:0] cpa_base_t;

  typedef enum logic [1:0] {
    cpa_locked,
    cpa_key_half,
    cpa_open
  } cpa_lock_t;
endpackage

// ### logic/cpa_unlock.sv
// Key sequencer: tracks locked, half-keyed and configuration mode.
// Assumes key_wr pulses once per write to the enable port.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
module cpa_unlock (
  // Clock and reset
  input  wire logic   clk_sys_in,
  input  wire logic   rst_in,
  input  wire logic   ce_in,
  // Core side
  cpa_core_if.unlock  ifc
);
  import cpa_pkg::*;

  cpa_lock_t state;
  cpa_lock_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      cpa_locked: begin
        if (ifc.key_wr && ifc.key_data == `CPA_KEY_ENTER) begin
          next_state = cpa_key_half;
        end
      end
      cpa_key_half: begin
        if (ifc.key_wr) begin
          // Second key opens, anything else starts over
          if (ifc.key_data == `CPA_KEY_ENTER) begin
            next_state = cpa_open;
          end else begin
            next_state = cpa_locked;
          end
        end
      end
      cpa_open: begin
        if (ifc.key_wr && ifc.key_data == `CPA_KEY_EXIT) begin
          next_state = cpa_locked;
        end
      end
      default: begin
        next_state = cpa_locked;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= cpa_locked;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  assign ifc.cfg_mode = (state == cpa_open);
endmodule // cpa_unlock

// ### sim/cpa_host_model.sv
// Host I/O cycle model: one strobe cycle per access, 1 ns after an edge.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
module cpa_host_model (
  // Clock
  input  wire logic          clk_sys_in,
  // Host I/O cycles
  output logic [15:0]        io_addr_out,
  output cpa_pkg::cpa_byte_t io_wdata_out,
  output logic               io_wr_out,
  output logic               io_rd_out
);
  import cpa_pkg::*;
  initial begin
    io_addr_out = 16'h0000;
    io_wdata_out = 8'h00;
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
  end
  // One cycle; calls may follow back to back
  task automatic cycle(input logic wr, input logic rd,
                       input logic [15:0] a, input cpa_byte_t d);
    @(posedge clk_sys_in);
    #1;
    io_wr_out = wr;
    io_rd_out = rd;
    io_addr_out = a;
    io_wdata_out = d;
  endtask
  // Released bus shows inverted values, changing every cycle
  task automatic rest(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
      io_wr_out = 1'b0;
      io_rd_out = 1'b0;
      io_addr_out = ~io_addr_out;
      io_wdata_out = ~io_wdata_out;
    end
  endtask
  task automatic enter(input logic [15:0] p);
    cycle(1'b1, 1'b0, p, 8'h87);
    cycle(1'b1, 1'b0, p, 8'h87);
  endtask
  task automatic leave(input logic [15:0] p);
    cycle(1'b1, 1'b0, p, 8'haa);
  endtask
  task automatic put(input logic [15:0] p, input cpa_byte_t i,
                     input cpa_byte_t d);
    cycle(1'b1, 1'b0, p, i);
    cycle(1'b1, 1'b0, p + 16'h0001, d);
  endtask
endmodule // cpa_host_model

// ### sim/cpa_port_monitor.sv
// Checker for the configuration access port, bound to its top module.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
module cpa_port_monitor (
  // Clock and reset
  input wire logic                        clk_sys_in,
  input wire logic                        rst_in,
  input wire logic                        ce_in,
  // Host cycles
  input wire logic [15:0]                 io_addr_in,
  input wire cpa_pkg::cpa_byte_t          io_wdata_in,
  input wire logic                        io_wr_in,
  input wire logic                        io_rd_in,
  input wire logic                        io_rvalid_out,
  // Configuration state
  input wire logic                        cfg_mode_out,
  input wire cpa_pkg::cpa_dev_t           cur_device_out,
  input wire logic                        alt_port_out,
  input wire logic [`CPA_NUM_DEV-1:0]     dev_active_out,
  input wire logic [`CPA_NUM_DEV*12-1:0]  dev_base_out
);
  import cpa_pkg::*;
  logic [15:0] port;
  logic        wr_p;
  logic        rd_d;
  assign port = alt_port_out ? `CPA_PORT_ALT : `CPA_PORT_PRI;
  assign wr_p = ce_in && io_wr_in && io_addr_in == port;
  assign rd_d = ce_in && io_rd_in && io_addr_in == port + `CPA_PORT_STEP;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_rvalid_cause: assert property (
    io_rvalid_out |-> $past(io_rd_in && ce_in))
    else $error("read answer without a read");
  a_read_answer: assert property (
    rd_d && cfg_mode_out |=> io_rvalid_out)
    else $error("data port read not answered");
  a_locked_mute: assert property (
    ce_in && io_rd_in && !cfg_mode_out |=> !io_rvalid_out)
    else $error("read answered while locked");
  a_alt_moves: assert property (
    ce_in && io_rd_in && alt_port_out && io_addr_in == 16'h002f
    |=> !io_rvalid_out)
    else $error("old data port answered after move");
  a_enter_pair: assert property (
    (wr_p && io_wdata_in == `CPA_KEY_ENTER && !cfg_mode_out) ##1
    (wr_p && io_wdata_in == `CPA_KEY_ENTER) |=> cfg_mode_out)
    else $error("two entry keys did not open");
  a_mode_rise: assert property (
    $rose(cfg_mode_out) |-> $past(io_wr_in && io_wdata_in == 8'h87))
    else $error("configuration opened without key");
  a_exit_key: assert property (
    wr_p && io_wdata_in == `CPA_KEY_EXIT && cfg_mode_out
    |=> !cfg_mode_out)
    else $error("exit key did not close");
  a_dev_latch: assert property (
    !$past(rst_in) && $changed(cur_device_out) |->
    $past(ce_in && io_wr_in && cfg_mode_out
          && io_addr_in == port + `CPA_PORT_STEP)
    && (cur_device_out == $past(io_wdata_in[3:0])
        || cur_device_out == 4'h0))
    else $error("device changed without data write");
  a_state_hold: assert property (
    !$past(rst_in) && !$past(io_wr_in)
    |-> $stable(dev_base_out) && $stable(dev_active_out))
    else $error("device state changed without a write");
  a_dev4_inert: assert property (
    !dev_active_out[4] && dev_base_out[59:48] == 12'h000)
    else $error("reserved device shows state");

  c_read: cover property (io_rvalid_out);
  c_open: cover property ($rose(cfg_mode_out));
  c_alt: cover property ($rose(alt_port_out));
  c_dev_f: cover property (cur_device_out == 4'hf);
endmodule // cpa_port_monitor

bind cpa_config_port cpa_port_monitor u_mon (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
  .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
  .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
  .io_rvalid_out(io_rvalid_out), .cfg_mode_out(cfg_mode_out),
  .cur_device_out(cur_device_out), .alt_port_out(alt_port_out),
  .dev_active_out(dev_active_out), .dev_base_out(dev_base_out));

// ### sim/tb.sv
// Bench for the configuration access port; a watcher compares each
// read answer with the oldest queued expectation. Needs the host model.
`timescale 1ns/1ns
`include "cpa_cfg.svh"
module tb;
  import cpa_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         ce = 1'b1;
  logic         alt_strap = 1'b0;
  logic [15:0]  io_addr;
  cpa_byte_t    io_wdata;
  cpa_byte_t    io_rdata;
  logic         io_wr;
  logic         io_rd;
  logic         io_rvalid;
  logic         cfg_mode;
  logic         alt_port;
  cpa_dev_t     cur_dev;
  logic [15:0]  active;
  logic [15:0]  exp_act = 16'h0000;
  logic [191:0] base;
  logic [31:0]  seed = 32'h9a9b5386;
  cpa_byte_t    exp_q[$];
  cpa_byte_t    val[16];
  cpa_byte_t    gi[5] = '{8'h22, 8'h23, 8'h24, 8'h2c, 8'h20};
  cpa_byte_t    gv[5] = '{8'hff, 8'hf0, 8'h40, 8'h02, 8'h5a};
  int           err_count = 0;
  int           checked = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  cpa_config_port dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
    .io_addr_in(io_addr), .io_wdata_in(io_wdata), .io_wr_in(io_wr),
    .io_rd_in(io_rd), .io_rdata_out(io_rdata), .io_rvalid_out(io_rvalid),
    .alt_strap_in(alt_strap), .cfg_mode_out(cfg_mode),
    .cur_device_out(cur_dev), .alt_port_out(alt_port),
    .dev_active_out(active), .dev_base_out(base));
  cpa_host_model host (
    .clk_sys_in(clk_sys_in), .io_addr_out(io_addr),
    .io_wdata_out(io_wdata), .io_wr_out(io_wr), .io_rd_out(io_rd));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] p, input cpa_byte_t i,
                    input cpa_byte_t e);
    host.cycle(1'b1, 1'b0, p, i);
    exp_q.push_back(e);
    host.cycle(1'b0, 1'b1, p + 16'h0001, 8'h00);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(negedge clk_sys_in) begin
    if (io_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unasked read answer", 16'h0000, 16'h0001);
      end else begin
        chk("read data", 16'(exp_q.pop_front()), 16'(io_rdata));
      end
    end
  end

  initial begin
    logic [31:0] r;
    repeat (8) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    host.rest(3);
    chk("base dev0", 16'h03f0, 16'(base[11:0]));
    chk("base dev2", 16'h03f8, 16'(base[35:24]));
    host.cycle(1'b0, 1'b1, 16'h002f, 8'h00);
    host.cycle(1'b1, 1'b0, 16'h002e, 8'h87);
    host.cycle(1'b1, 1'b0, 16'h002e, 8'h55);
    host.cycle(1'b1, 1'b0, 16'h002e, 8'h87);
    host.rest(1);
    chk("mode restart", 16'h0000, 16'(cfg_mode));
    // Frozen keys must neither open nor lose the half-keyed state
    ce = 1'b0;
    host.enter(16'h002e);
    host.rest(1);
    chk("mode frozen", 16'h0000, 16'(cfg_mode));
    ce = 1'b1;
    host.cycle(1'b1, 1'b0, 16'h002e, 8'h87);
    host.rest(1);
    chk("mode open", 16'h0001, 16'(cfg_mode));
    // Read-only identity must ignore writes
    host.put(16'h002e, 8'h20, 8'hff);
    for (int i = 0; i < 5; i++) rd(16'h002e, gi[i], gv[i]);
    for (int d = 0; d < 16; d++) begin
      r = rnd();
      val[d] = r[7:0];
      exp_act[d] = (d != 4) && r[0];
      host.put(16'h002e, 8'h07, 8'(d));
      host.rest(1);
      chk("device", 16'(d), 16'(cur_dev));
      host.put(16'h002e, 8'h30, val[d]);
    end
    host.rest(1);
    chk("active", exp_act, active);
    for (int d = 0; d < 16; d++) begin
      host.put(16'h002e, 8'h07, 8'(d));
      rd(16'h002e, 8'h07, 8'(d));
      rd(16'h002e, 8'h30, d == 4 ? 8'h00 : val[d]);
    end
    host.put(16'h002e, 8'h07, 8'h02);
    host.put(16'h002e, 8'h60, 8'h03);
    host.put(16'h002e, 8'h61, 8'he8);
    host.put(16'h002e, 8'h07, 8'h08);
    host.put(16'h002e, 8'h61, 8'h55);
    rd(16'h002e, 8'h61, 8'h00);
    host.rest(1);
    chk("base dev2 new", 16'h03e8, 16'(base[35:24]));
    chk("base dev8", 16'h0000, 16'(base[107:96]));
    host.put(16'h002e, 8'h26, 8'h40);
    host.rest(1);
    chk("alt port", 16'h0001, 16'(alt_port));
    host.cycle(1'b0, 1'b1, 16'h002f, 8'h00);
    rd(16'h004e, 8'h26, 8'h40);
    host.leave(16'h004e);
    host.rest(1);
    chk("mode exit", 16'h0000, 16'(cfg_mode));
    host.cycle(1'b1, 1'b0, 16'h004f, 8'h00);
    host.rest(1);
    chk("alt locked", 16'h0001, 16'(alt_port));
    host.enter(16'h004e);
    host.rest(1);
    chk("mode reenter", 16'h0001, 16'(cfg_mode));
    host.put(16'h004e, 8'h26, 8'h00);
    host.leave(16'h002e);
    host.rest(1);
    chk("alt back", 16'h0000, 16'(alt_port));
    chk("mode final", 16'h0000, 16'(cfg_mode));
    // Mid-run reset with the strap high moves the ports
    alt_strap = 1'b1;
    rst_in = 1'b1;
    host.rest(2);
    rst_in = 1'b0;
    host.rest(2);
    chk("strap alt", 16'h0001, 16'(alt_port));
    chk("reset device", 16'h0000, 16'(cur_dev));
    chk("reset base dev2", 16'h03f8, 16'(base[35:24]));
    host.enter(16'h004e);
    rd(16'h004e, 8'h26, 8'h40);
    for (int i = 0; i < 8 && exp_q.size() > 0; i++) host.rest(1);
    if (exp_q.size() > 0) begin
      err_count++;
      $display("ERROR read answers expected %0d seen 0", exp_q.size());
    end
    close_out();
  end
endmodule // tb
